// ### ssq_pkg.sv
// Shared types, constants and helpers of the stack push/pop sequencer
package ssq_pkg;

    // ------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------
    localparam int XW = 64;

    typedef enum logic [1:0] {
        SSQ_PUSH    = 2'b00,
        SSQ_POP     = 2'b01,
        SSQ_POPRET  = 2'b10,
        SSQ_POPRETZ = 2'b11
    } ssq_op_t;

    typedef enum logic [1:0] {
        SSQ_RV32I = 2'b00,
        SSQ_RV64I = 2'b01,
        SSQ_RV32E = 2'b10
    } ssq_base_t;

    // ------------------------------------------------------------
    // Register list and frame constants
    // ------------------------------------------------------------
    localparam logic [3:0] RLIST_MIN = 4'h4;
    localparam logic [3:0] RLIST_E_MAX = 4'h6;
    localparam logic [3:0] RLIST_FULL = 4'hF;
    localparam logic [3:0] RLIST_BIAS = 4'h3;
    localparam logic [3:0] FULL_COUNT = 4'hD;
    localparam logic [3:0] POS_S2 = 4'h3;
    localparam logic [4:0] REG_RA = 5'h01;
    localparam logic [4:0] REG_S0 = 5'h08;
    localparam logic [4:0] REG_S2 = 5'h12;
    localparam logic [7:0] ADJ_UNIT = 8'h10;
    localparam logic [1:0] SIZE_W = 2'h2;
    localparam logic [1:0] SIZE_D = 2'h3;
    localparam logic [7:0] BYTES_W = 8'h04;
    localparam logic [7:0] BYTES_D = 8'h08;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        ssq_op_t op;
        logic [3:0] rlist;
        logic [1:0] spimm;
        logic [XW-1:0] sp;
        logic [XW-1:0] pc;
    } ssq_instr_t;

    typedef struct packed {
        logic vld;
        logic wr;
        logic [1:0] size;
        logic [4:0] reg_idx;
        logic [XW-1:0] addr;
    } ssq_mem_req_t;

    typedef struct packed {
        logic fault;
        logic [XW-1:0] data;
    } ssq_mem_rsp_t;

    typedef struct packed {
        logic vld;
        logic [4:0] idx;
        logic [XW-1:0] data;
    } ssq_rf_wr_t;

    typedef struct packed {
        logic vld;
        logic [XW-1:0] sp;
        logic a0_zero;
        logic jump;
        logic [XW-1:0] target;
    } ssq_commit_t;

    typedef struct packed {
        logic vld;
        logic [XW-1:0] epc;
        logic [XW-1:0] tval;
        logic [5:0] cause;
    } ssq_trap_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Position 0 is the return address, counting upward
    function automatic logic [4:0] ssq_pos_to_reg(input logic [3:0] pos);
        logic [4:0] r;
        r = REG_RA;
        if (pos == 4'h0) begin
            r = REG_RA;
        end else if (pos < POS_S2) begin
            r = REG_S0 + {1'b0, pos} - 5'h01;
        end else begin
            r = REG_S2 + {1'b0, pos - POS_S2};
        end
        return r;
    endfunction

    function automatic logic [7:0] ssq_bytes(input ssq_base_t b);
        return (b == SSQ_RV64I) ? BYTES_D : BYTES_W;
    endfunction

endpackage

// ### ssq_rlist_dec.sv
// Register list decode and frame size of the stack sequencer
module ssq_rlist_dec (
    input wire logic [3:0] i_rlist,
    input wire logic [1:0] i_spimm,
    input wire ssq_pkg::ssq_base_t i_base,
    output logic o_valid,
    output logic [3:0] o_count,
    output logic [7:0] o_adj
);
    logic [7:0] units;

    always_comb begin
        o_valid = 1'b1;
        units = 8'h00;
        // Codes below four are held back for a later variant
        if (i_rlist < ssq_pkg::RLIST_MIN) begin
            o_valid = 1'b0;
        end
        // No list stops at s10: the last code jumps to s11
        if (i_rlist == ssq_pkg::RLIST_FULL) begin
            o_count = ssq_pkg::FULL_COUNT;
        end else begin
            o_count = i_rlist - ssq_pkg::RLIST_BIAS;
        end
        unique case (i_base)
            ssq_pkg::SSQ_RV32I: begin
                if (i_rlist == ssq_pkg::RLIST_FULL) begin
                    units = 8'h04;
                end else begin
                    units = {6'h00, i_rlist[3:2]};
                end
            end
            ssq_pkg::SSQ_RV64I: begin
                if (i_rlist == ssq_pkg::RLIST_FULL) begin
                    units = 8'h07;
                end else begin
                    units = {5'h00, i_rlist[3:1]} - 8'h01;
                end
            end
            ssq_pkg::SSQ_RV32E: begin
                units = 8'h01;
                // Only ra, s0 and s1 exist on the embedded base
                if (i_rlist > ssq_pkg::RLIST_E_MAX) begin
                    o_valid = 1'b0;
                end
            end
            default: begin
                o_valid = 1'b0;
            end
        endcase
        o_adj = ssq_pkg::ADJ_UNIT * (units + {6'h00, i_spimm});
    end
endmodule // ssq_rlist_dec

// ### ssq_addr_gen.sv
// Address of one access within a push or pop frame
module ssq_addr_gen (
    input wire ssq_pkg::ssq_op_t i_op,
    input wire ssq_pkg::ssq_base_t i_base,
    input wire logic [ssq_pkg::XW-1:0] i_sp,
    input wire logic [7:0] i_adj,
    input wire logic [3:0] i_step,
    output logic [ssq_pkg::XW-1:0] o_addr,
    output logic [1:0] o_size
);
    logic [ssq_pkg::XW-1:0] offs;
    logic [ssq_pkg::XW-1:0] top;
    logic [ssq_pkg::XW-1:0] raw;

    always_comb begin
        offs = ssq_pkg::XW'(ssq_bytes_mul(i_base, i_step));
        if (i_op == ssq_pkg::SSQ_PUSH) begin
            top = i_sp;
        end else begin
            top = i_sp + {56'h0, i_adj};
        end
        raw = top - offs;
        // Upper half is dropped on the narrow bases
        if (i_base == ssq_pkg::SSQ_RV64I) begin
            o_addr = raw;
            o_size = ssq_pkg::SIZE_D;
        end else begin
            o_addr = {32'h0, raw[31:0]};
            o_size = ssq_pkg::SIZE_W;
        end
    end

    function automatic logic [11:0] ssq_bytes_mul(
        input ssq_pkg::ssq_base_t b,
        input logic [3:0] s
    );
        return {4'h0, ssq_pkg::ssq_bytes(b)} * ({8'h00, s} + 12'h001);
    endfunction
endmodule // ssq_addr_gen

// ### ssq_seq.sv
// Push/pop stack frame sequencer, top level
module ssq_seq #(
    parameter bit NONIDEM_OK = 1'b0,
    parameter logic [5:0] ILLEGAL_CAUSE = 6'h02,
    parameter logic [5:0] LOAD_FAULT_CAUSE = 6'h05,
    parameter logic [5:0] STORE_FAULT_CAUSE = 6'h07
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire ssq_pkg::ssq_instr_t i_instr,
    input wire ssq_pkg::ssq_base_t i_base,
    input wire logic i_region_nonidem,
    input wire logic i_mem_ready,
    input wire logic i_mem_rsp_vld,
    input wire ssq_pkg::ssq_mem_rsp_t i_mem_rsp,
    output ssq_pkg::ssq_mem_req_t o_mem_req,
    output ssq_pkg::ssq_rf_wr_t o_rf_wr,
    output ssq_pkg::ssq_commit_t o_commit,
    output ssq_pkg::ssq_trap_t o_trap,
    output logic o_busy
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT = 3'b011,
        ST_COMMIT = 3'b100,
        ST_TRAP = 3'b101
    } ssq_state_t;

    ssq_state_t state_ff;
    ssq_state_t nxt_state;
    ssq_pkg::ssq_instr_t instr_ff;
    ssq_pkg::ssq_base_t base_ff;
    logic nonidem_ff;
    logic [3:0] step_ff;
    logic [3:0] nxt_step;
    logic [ssq_pkg::XW-1:0] ra_ff;
    logic [ssq_pkg::XW-1:0] fault_addr_ff;
    logic [5:0] fault_cause_ff;
    ssq_pkg::ssq_mem_req_t mem_req_ff;
    ssq_pkg::ssq_rf_wr_t rf_wr_ff;
    ssq_pkg::ssq_commit_t commit_ff;
    ssq_pkg::ssq_trap_t trap_ff;
    logic busy_ff;

    logic dec_valid;
    logic [3:0] dec_count;
    logic [7:0] dec_adj;
    logic [ssq_pkg::XW-1:0] gen_addr;
    logic [1:0] gen_size;
    logic is_push;
    logic accepted;
    logic rsp_ok;
    logic rsp_bad;
    logic last_step;
    logic [3:0] pos;

    // ------------------------------------------------------------
    // Decode and address generation
    // ------------------------------------------------------------
    ssq_rlist_dec u_dec (
        .i_rlist(instr_ff.rlist),
        .i_spimm(instr_ff.spimm),
        .i_base(base_ff),
        .o_valid(dec_valid),
        .o_count(dec_count),
        .o_adj(dec_adj)
    );

    ssq_addr_gen u_addr (
        .i_op(instr_ff.op),
        .i_base(base_ff),
        .i_sp(instr_ff.sp),
        .i_adj(dec_adj),
        .i_step(nxt_step),
        .o_addr(gen_addr),
        .o_size(gen_size)
    );

    assign is_push = (instr_ff.op == ssq_pkg::SSQ_PUSH);
    assign accepted = mem_req_ff.vld && i_mem_ready;
    assign rsp_ok = (state_ff == ST_WAIT) && i_mem_rsp_vld &&
                    !i_mem_rsp.fault;
    assign rsp_bad = (state_ff == ST_WAIT) && i_mem_rsp_vld &&
                     i_mem_rsp.fault;
    assign last_step = (step_ff + 4'h1 == dec_count);
    // Step zero is the highest register, so positions run downward
    assign pos = dec_count - 4'h1 - step_ff;

    // ------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------
    // One access in flight at a time; a fixed descending order is
    // one of the orders the frame allows and keeps faults precise
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_step = 4'h0;
                if (i_start) begin
                    nxt_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                nxt_step = 4'h0;
                if (!dec_valid) begin
                    nxt_state = ST_TRAP;
                end else if (nonidem_ff && !NONIDEM_OK) begin
                    nxt_state = ST_TRAP;
                end else begin
                    nxt_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (accepted) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rsp_bad) begin
                    nxt_state = ST_TRAP;
                end else if (rsp_ok && last_step) begin
                    nxt_state = ST_COMMIT;
                end else if (rsp_ok) begin
                    nxt_step = step_ff + 4'h1;
                    nxt_state = ST_ISSUE;
                end
            end
            ST_COMMIT: begin
                nxt_state = ST_IDLE;
            end
            ST_TRAP: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= ST_IDLE;
            step_ff <= 4'h0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Instruction capture
    // ------------------------------------------------------------
    // Whole instruction is latched so a retry after a trap starts
    // from the same sp and the same frame
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            instr_ff <= '0;
            base_ff <= ssq_pkg::SSQ_RV32I;
            nonidem_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && i_start) begin
            instr_ff <= i_instr;
            base_ff <= i_base;
            nonidem_ff <= i_region_nonidem;
        end
    end

    // ------------------------------------------------------------
    // Memory request
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_req_ff <= '0;
        end else if (nxt_state == ST_ISSUE && state_ff != ST_ISSUE) begin
            mem_req_ff.vld <= 1'b1;
            mem_req_ff.wr <= is_push;
            mem_req_ff.size <= gen_size;
            mem_req_ff.addr <= gen_addr;
            mem_req_ff.reg_idx <= ssq_pkg::ssq_pos_to_reg(
                dec_count - 4'h1 - nxt_step);
        end else if (accepted) begin
            mem_req_ff.vld <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Load write-back
    // ------------------------------------------------------------
    // Loaded registers are written at once; a later fault leaves
    // them changed, which the retry overwrites
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rf_wr_ff <= '0;
        end else if (rsp_ok && !is_push) begin
            rf_wr_ff.vld <= 1'b1;
            rf_wr_ff.idx <= ssq_pkg::ssq_pos_to_reg(pos);
            rf_wr_ff.data <= i_mem_rsp.data;
        end else if (state_ff == ST_COMMIT &&
                     instr_ff.op == ssq_pkg::SSQ_POPRETZ) begin
            rf_wr_ff.vld <= 1'b1;
            rf_wr_ff.idx <= 5'h0A;
            rf_wr_ff.data <= '0;
        end else begin
            rf_wr_ff.vld <= 1'b0;
        end
    end

    // Return target is the loaded ra, held for the final group
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ra_ff <= '0;
        end else if (rsp_ok && !is_push && pos == 4'h0) begin
            ra_ff <= i_mem_rsp.data;
        end
    end

    // ------------------------------------------------------------
    // Final atomic group
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            commit_ff <= '0;
        end else if (state_ff == ST_WAIT && nxt_state == ST_COMMIT) begin
            commit_ff.vld <= 1'b1;
            if (is_push) begin
                commit_ff.sp <= instr_ff.sp - {56'h0, dec_adj};
            end else begin
                commit_ff.sp <= instr_ff.sp + {56'h0, dec_adj};
            end
            commit_ff.a0_zero <= (instr_ff.op == ssq_pkg::SSQ_POPRETZ);
            commit_ff.jump <= (instr_ff.op == ssq_pkg::SSQ_POPRET) ||
                              (instr_ff.op == ssq_pkg::SSQ_POPRETZ);
            if (pos == 4'h0) begin
                commit_ff.target <= i_mem_rsp.data;
            end else begin
                commit_ff.target <= ra_ff;
            end
        end else begin
            commit_ff.vld <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Trap reporting
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_addr_ff <= '0;
            fault_cause_ff <= 6'h00;
        end else if (state_ff == ST_CHECK) begin
            fault_addr_ff <= gen_addr;
            if (!dec_valid) begin
                fault_cause_ff <= ILLEGAL_CAUSE;
            end else if (is_push) begin
                fault_cause_ff <= STORE_FAULT_CAUSE;
            end else begin
                fault_cause_ff <= LOAD_FAULT_CAUSE;
            end
        end else if (rsp_bad) begin
            fault_addr_ff <= mem_req_ff.addr;
            fault_cause_ff <= is_push ? STORE_FAULT_CAUSE : LOAD_FAULT_CAUSE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trap_ff <= '0;
        end else if (state_ff == ST_TRAP) begin
            trap_ff.vld <= 1'b1;
            trap_ff.epc <= instr_ff.pc;
            trap_ff.tval <= (fault_cause_ff == ILLEGAL_CAUSE) ?
                            '0 : fault_addr_ff;
            trap_ff.cause <= fault_cause_ff;
        end else begin
            trap_ff.vld <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_mem_req = mem_req_ff;
    assign o_rf_wr = rf_wr_ff;
    assign o_commit = commit_ff;
    assign o_trap = trap_ff;
    assign o_busy = busy_ff;

endmodule // ssq_seq

// ### ssq_seq_asserts.sv
// Port-level checks of the stack push/pop sequencer
module ssq_seq_chk #(
    parameter bit NONIDEM_OK = 1'b0,
    parameter logic [5:0] ILLEGAL_CAUSE = 6'h02,
    parameter logic [5:0] LOAD_FAULT_CAUSE = 6'h05,
    parameter logic [5:0] STORE_FAULT_CAUSE = 6'h07
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire ssq_pkg::ssq_instr_t i_instr,
    input wire ssq_pkg::ssq_base_t i_base,
    input wire logic i_region_nonidem,
    input wire logic i_mem_ready,
    input wire logic i_mem_rsp_vld,
    input wire ssq_pkg::ssq_mem_rsp_t i_mem_rsp,
    input wire ssq_pkg::ssq_mem_req_t o_mem_req,
    input wire ssq_pkg::ssq_rf_wr_t o_rf_wr,
    input wire ssq_pkg::ssq_commit_t o_commit,
    input wire ssq_pkg::ssq_trap_t o_trap,
    input wire logic o_busy
);
    logic take;
    logic outst_ff;
    logic fault_ff;
    ssq_pkg::ssq_op_t op_ff;
    logic [63:0] pc_ff;
    assign take = i_start && !o_busy;
    // Fault memory lives until the next accepted instruction
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            outst_ff <= 1'b0;
            fault_ff <= 1'b0;
            op_ff <= ssq_pkg::SSQ_PUSH;
            pc_ff <= '0;
        end else begin
            if (o_mem_req.vld && i_mem_ready) outst_ff <= 1'b1;
            else if (i_mem_rsp_vld) outst_ff <= 1'b0;
            if (take) fault_ff <= 1'b0;
            else if (i_mem_rsp_vld && i_mem_rsp.fault) fault_ff <= 1'b1;
            if (take) op_ff <= i_instr.op;
            if (take) pc_ff <= i_instr.pc;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    AST_REQ_HOLD: assert property (
        o_mem_req.vld && !i_mem_ready |=> o_mem_req.vld && $stable(o_mem_req))
        else $error("request changed before accept");
    AST_ONE_OUT: assert property (
        outst_ff |-> !o_mem_req.vld) else $error("second access outstanding");
    AST_NO_COMMIT: assert property (
        fault_ff |-> !o_commit.vld) else $error("commit after fault");
    AST_EPC: assert property (
        o_trap.vld |-> o_trap.epc == pc_ff) else $error("trap pc wrong");
    AST_RET: assert property (
        o_commit.vld |-> o_commit.jump == op_ff[1]
            && o_commit.a0_zero == (op_ff == ssq_pkg::SSQ_POPRETZ))
        else $error("return flags wrong");
    AST_A0: assert property (
        o_commit.vld && o_commit.a0_zero |=> o_rf_wr.vld
            && o_rf_wr.idx == 5'h0A && o_rf_wr.data == '0)
        else $error("a0 zero write missing");
    AST_RESV: assert property (
        take && i_instr.rlist < 4'h4 |-> ##1 !o_mem_req.vld [*2] ##[0:1]
            (o_trap.vld && o_trap.cause == ILLEGAL_CAUSE))
        else $error("reserved list not trapped");
    AST_NONIDEM: assert property (
        take && i_region_nonidem && !NONIDEM_OK && i_instr.rlist >= 4'h4
            && i_base == ssq_pkg::SSQ_RV32I |-> !o_mem_req.vld [*3] ##[0:1]
            (o_trap.vld && o_trap.cause == (op_ff == ssq_pkg::SSQ_PUSH ?
            STORE_FAULT_CAUSE : LOAD_FAULT_CAUSE)))
        else $error("non-idempotent access not refused");
endmodule // ssq_seq_chk

bind ssq_seq ssq_seq_chk #(
    .NONIDEM_OK(NONIDEM_OK),
    .ILLEGAL_CAUSE(ILLEGAL_CAUSE),
    .LOAD_FAULT_CAUSE(LOAD_FAULT_CAUSE),
    .STORE_FAULT_CAUSE(STORE_FAULT_CAUSE)
) u_chk (.i_sys_clk, .i_reset_n, .i_start, .i_instr, .i_base,
    .i_region_nonidem, .i_mem_ready, .i_mem_rsp_vld, .i_mem_rsp,
    .o_mem_req, .o_rf_wr, .o_commit, .o_trap, .o_busy);

// ### ssq_mem_model.sv
// Behavioural load/store unit and stack memory facing the sequencer
module ssq_mem_model (
    input wire logic i_sys_clk,
    input wire ssq_pkg::ssq_mem_req_t i_req,
    input wire logic [3:0] i_stall,
    input wire logic [3:0] i_lat,
    input wire logic i_fault_en,
    input wire logic [63:0] i_fault_addr,
    output logic o_ready,
    output logic o_rsp_vld,
    output ssq_pkg::ssq_mem_rsp_t o_rsp
);
    timeunit 1ns;
    timeprecision 1ns;
    logic took = 1'b0;
    logic pend = 1'b0;
    logic [3:0] cnt = 4'h0;
    ssq_pkg::ssq_mem_req_t held = '0;
    initial begin
        o_ready = 1'b0;
        o_rsp_vld = 1'b0;
        o_rsp = '0;
    end
    always @(posedge i_sys_clk) begin
        took <= i_req.vld && o_ready;
        if (i_req.vld && o_ready) held <= i_req;
    end
    // Data toggles when idle so a stale value never looks valid
    always @(negedge i_sys_clk) begin
        o_rsp_vld <= 1'b0;
        o_rsp.data <= ~o_rsp.data;
        if (took) begin
            o_ready <= 1'b0;
            pend <= 1'b1;
            cnt <= i_lat;
        end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend) begin
            o_rsp_vld <= 1'b1;
            o_rsp.fault <= i_fault_en && held.addr == i_fault_addr;
            o_rsp.data <= {32'h0, held.addr[31:0] ^ 32'h5A5A0000};
            pend <= 1'b0;
        end else if (i_req.vld && !o_ready) begin
            if (cnt >= i_stall) o_ready <= 1'b1;
            else cnt <= cnt + 4'h1;
        end
    end
endmodule // ssq_mem_model

// ### test_stack_push_pop_sequencer.sv
// Self-checking bench of the stack push/pop sequencer
module test_stack_push_pop_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_start = 1'b0;
    ssq_pkg::ssq_instr_t i_instr = '0;
    ssq_pkg::ssq_base_t i_base = ssq_pkg::SSQ_RV32I;
    logic i_region_nonidem = 1'b0;
    logic i_mem_ready;
    logic i_mem_rsp_vld;
    ssq_pkg::ssq_mem_rsp_t i_mem_rsp;
    ssq_pkg::ssq_mem_req_t o_mem_req;
    ssq_pkg::ssq_rf_wr_t o_rf_wr;
    ssq_pkg::ssq_commit_t o_commit;
    ssq_pkg::ssq_trap_t o_trap;
    logic o_busy;
    logic [3:0] stall = 4'h0;
    logic [3:0] lat = 4'h0;
    logic flt = 1'b0;
    logic [63:0] flt_addr = '0;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int r_op, r_rl, r_sp, r_b;
    logic [63:0] r_s;
    ssq_pkg::ssq_mem_req_t acc_q[$];
    ssq_pkg::ssq_rf_wr_t wr_q[$];
    ssq_pkg::ssq_commit_t cm;
    ssq_pkg::ssq_trap_t tr;
    always #25 i_sys_clk = ~i_sys_clk;
    ssq_seq dut (.i_sys_clk, .i_reset_n, .i_start, .i_instr, .i_base,
        .i_region_nonidem, .i_mem_ready, .i_mem_rsp_vld, .i_mem_rsp,
        .o_mem_req, .o_rf_wr, .o_commit, .o_trap, .o_busy);
    ssq_mem_model mem (.i_sys_clk, .i_req(o_mem_req), .i_stall(stall),
        .i_lat(lat), .i_fault_en(flt), .i_fault_addr(flt_addr),
        .o_ready(i_mem_ready), .o_rsp_vld(i_mem_rsp_vld), .o_rsp(i_mem_rsp));
    // Ceiling is over ten times the expected run length
    always @(posedge i_sys_clk) begin
        cyc++;
        if (o_mem_req.vld && i_mem_ready) acc_q.push_back(o_mem_req);
        if (o_rf_wr.vld) wr_q.push_back(o_rf_wr);
        if (o_commit.vld) cm = o_commit;
        if (o_trap.vld) tr = o_trap;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [4:0] reg_at(input int pos);
        if (pos == 0) return 5'h01;
        if (pos < 3) return 5'(7 + pos);
        return 5'(15 + pos);
    endfunction
    function automatic int adj(input int b, input int rl, input int sp);
        int a;
        if (b != 1) a = (rl == 15) ? 64 : 16 * ((rl - 4) / 4 + 1);
        else if (rl >= 14) a = 96 + 16 * (rl - 14);
        else a = 16 * ((rl - 4) / 2 + 1);
        return a + 16 * sp;
    endfunction
    task automatic run(input int op, input int rl, input int sp,
                       input int b, input logic [63:0] s, input logic ni);
        int n;
        {r_op, r_rl, r_sp, r_b, r_s} = {op, rl, sp, b, s};
        acc_q.delete();
        wr_q.delete();
        cm = '0;
        tr = '0;
        @(negedge i_sys_clk);
        i_start = 1'b1;
        i_instr = {2'(op), 4'(rl), 2'(sp), s, 64'h1000 + 64'(rl)};
        i_base = ssq_pkg::ssq_base_t'(b);
        i_region_nonidem = ni;
        @(negedge i_sys_clk);
        i_start = 1'b0;
        n = 0;
        while (!cm.vld && !tr.vld && n < 300) begin
            @(negedge i_sys_clk);
            n++;
        end
        repeat (2) @(negedge i_sys_clk);
    endtask
    task automatic chk_seq();
        int n;
        int by;
        int a;
        logic [63:0] top;
        logic [63:0] ea;
        n = (r_rl == 15) ? 13 : r_rl - 3;
        by = (r_b == 1) ? 8 : 4;
        a = adj(r_b, r_rl, r_sp);
        top = (r_op == 0) ? r_s : r_s + 64'(a);
        chk(acc_q.size(), n);
        foreach (acc_q[k]) begin
            // Narrow bases drive zero in the upper address half
            ea = (top - 64'(by * (k + 1))) & {{32{by == 8}}, 32'hFFFF_FFFF};
            chk(acc_q[k].addr, ea);
            chk(acc_q[k].reg_idx, reg_at(n - 1 - k));
            chk({acc_q[k].wr, acc_q[k].size}, {r_op == 0, 2'(by / 4 + 1)});
            if (r_op != 0) chk(wr_q[k], {1'b1, reg_at(n - 1 - k), 32'h0,
                ea[31:0] ^ 32'h5A5A0000});
        end
        chk(cm.sp, (r_op == 0) ? r_s - 64'(a) : r_s + 64'(a));
        chk({cm.vld, cm.jump, cm.a0_zero}, {1'b1, r_op >= 2, r_op == 3});
        if (r_op >= 2) chk(cm.target, {32'h0, 32'(top - 64'(by * n))
            ^ 32'h5A5A0000});
        if (r_op == 3) chk(wr_q[n], {1'b1, 5'h0A, 64'h0});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_frames();
        for (int b = 0; b < 3; b++) begin
            for (int rl = 4; rl < 16; rl++) begin
                if (b == 2 && rl > 6) continue;
                stall = 4'(rl % 3);
                lat = 4'(rl % 2);
                run(rl % 4, rl, (rl + b) % 4, b, 64'h2_0000_8000, 1'b0);
                chk_seq();
            end
        end
        $display("frames done");
    endtask
    task automatic t_reserved();
        for (int rl = 0; rl < 6; rl++) begin
            run(rl % 4, (rl >= 4) ? 7 : rl, 0, (rl >= 4) ? rl - 2 : 0,
                64'h8000, 0);
            chk({tr.vld, tr.cause, tr.tval, cm.vld, o_busy},
                {1'b1, 6'h02, 64'h0, 1'b0, 1'b0});
            chk(acc_q.size(), 0);
        end
        $display("reserved done");
    endtask
    task automatic t_fault();
        flt = 1'b1;
        flt_addr = 64'h7FF8;
        run(0, 7, 3, 0, 64'h8000, 1'b0);
        chk({acc_q.size(), cm.vld}, {32'h2, 1'b0});
        chk({tr.vld, tr.cause, tr.tval}, {1'b1, 6'h07, 64'h7FF8});
        chk(tr.epc, 64'h1007);
        flt_addr = 64'h801C;
        run(1, 8, 1, 0, 64'h8000, 1'b0);
        chk(cm.vld, 1'b0);
        chk({tr.vld, tr.cause, tr.tval}, {1'b1, 6'h05, 64'h801C});
        flt = 1'b0;
        run(1, 8, 1, 0, 64'h8000, 1'b0);
        chk_seq();
        $display("fault done");
    endtask
    task automatic t_nonidem();
        run(0, 5, 0, 0, 64'h8000, 1'b1);
        chk({tr.vld, tr.cause, tr.tval}, {1'b1, 6'h07, 64'h7FFC});
        chk(acc_q.size(), 0);
        run(2, 5, 1, 1, 64'h8000, 1'b1);
        chk({tr.vld, tr.cause, tr.tval}, {1'b1, 6'h05, 64'h8018});
        $display("nonidem done");
    endtask
    initial begin
        repeat (6) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        t_reserved();
        t_frames();
        t_fault();
        t_nonidem();
        results();
    end
endmodule // test_stack_push_pop_sequencer
